// ==== logic/rfs_pkg.sv ====
// Functional notes
// - Secondary buffer mode field, reset crystal
// - Primary buffer mode field, reset differential
// - Synth B reference choice field, reset pin
// - Synth B pin: low/mid secondary, high auto
// - Synth A reference choice field, reset pin
// - Synth A pin: low primary, mid/high auto
// - Control bit skips the glitch-free multiplexer
// - Secondary crystal off after switch unless kept
// - Secondary buffer gain bit, reset maximum
// - Primary buffer gain bit, reset maximum
package rfs_pkg;

  // ==========================================================================
  // Register map
  // ==========================================================================
  // Byte offsets of the two registers on the plain register port.
  localparam logic [7:0] SEL_OFFSET = 8'h32;
  localparam logic [7:0] CTL_OFFSET = 8'h33;
  // Reset values: secondary crystal, primary differential, both pin-controlled.
  localparam logic [7:0] SEL_RESET = 8'h95;
  // Reset value: multiplexer used, crystal released, both gains maximum.
  localparam logic [7:0] CTL_RESET = 8'h03;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  // Low bit of each two-bit field of the select register.
  localparam int SEC_MODE_LSB = 6;
  localparam int PRI_MODE_LSB = 4;
  localparam int SYN_B_LSB = 2;
  localparam int SYN_A_LSB = 0;
  // Single bits of the control register.
  localparam int MUX_SKIP_BIT = 7;
  localparam int KEEP_ON_BIT = 2;
  localparam int SEC_GAIN_BIT = 1;
  localparam int PRI_GAIN_BIT = 0;

  // ==========================================================================
  // Encodings
  // ==========================================================================
  // Buffer modes; the primary buffer treats both upper codes as disabled.
  localparam logic [1:0] BUF_SINGLE = 2'h0;
  localparam logic [1:0] BUF_DIFF = 2'h1;
  localparam logic [1:0] BUF_CRYSTAL = 2'h2;
  localparam logic [1:0] BUF_OFF = 2'h3;
  // Reference choices of each synthesizer.
  localparam logic [1:0] CHOICE_AUTO = 2'h0;
  localparam logic [1:0] CHOICE_PIN = 2'h1;
  localparam logic [1:0] CHOICE_PRI = 2'h2;
  localparam logic [1:0] CHOICE_SEC = 2'h3;
  // Three-level pin as reported by the pad comparators; code 3 reads as high.
  localparam logic [1:0] PIN_LOW = 2'h0;
  localparam logic [1:0] PIN_MID = 2'h1;
  localparam logic [1:0] PIN_HIGH = 2'h2;

endpackage

// ==== logic/rfs_ref_chooser.sv ====
`timescale 1ns/1ps
// ============================================================================
// Reference chooser for one synthesizer
// ============================================================================
// Purely combinational; the caller registers the result.
module rfs_ref_chooser #(
  // One for synth B, whose pin table differs from that of synth A.
  parameter bit IS_SYNTH_B = 1'b0
) (
  // Configuration and conditions.
  input wire logic [1:0] i_choice,
  input wire logic [1:0] i_pin_level,
  input wire logic i_primary_lost,
  input wire logic i_secondary_lost,
  // Result: high when the secondary input feeds this synthesizer.
  output logic o_use_secondary
);

  // Automatic pick, kept apart so both the mode and the pin can use it.
  logic auto_sec;

  // Leave the primary only when it is lost and the secondary is alive.
  assign auto_sec = i_primary_lost && !i_secondary_lost;

  // Decode the choice; the pin only matters in pin-controlled mode.
  always_comb begin
    case (i_choice)
      rfs_pkg::CHOICE_AUTO: o_use_secondary = auto_sec;
      rfs_pkg::CHOICE_PRI: o_use_secondary = 1'b0;
      rfs_pkg::CHOICE_SEC: o_use_secondary = 1'b1;
      default: begin
        if (IS_SYNTH_B) begin
          // Low and mid force the secondary; high hands over to automatic.
          o_use_secondary = (i_pin_level[1]) ? auto_sec : 1'b1;
        end else begin
          // Low forces the primary; mid and high hand over to automatic.
          o_use_secondary = (i_pin_level == rfs_pkg::PIN_LOW) ? 1'b0 : auto_sec;
        end
      end
    endcase
  end

endmodule // rfs_ref_chooser

// ==== logic/rfs_reference_input_select.sv ====
`timescale 1ns/1ps
// ============================================================================
// Reference input selection and buffer configuration
// ============================================================================
// Holds the select and control registers, decodes them into buffer and
// multiplexer controls, and picks a reference for each synthesizer.
module rfs_reference_input_select (
  // Clock and reset.
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // Register port.
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  output logic [7:0] o_rd_data,
  // Pins and clock monitors, asynchronous to the core clock.
  input wire logic [1:0] i_ref_pin_level,
  input wire logic i_primary_lost,
  input wire logic i_secondary_lost,
  // Primary buffer controls.
  output logic [1:0] o_primary_buf_mode,
  output logic o_primary_buf_on,
  output logic o_primary_buf_gain_max,
  // Secondary buffer controls.
  output logic [1:0] o_secondary_buf_mode,
  output logic o_secondary_buf_on,
  output logic o_secondary_buf_gain_max,
  // Multiplexer and synthesizer reference controls.
  output logic o_glitchfree_mux_skip,
  output logic o_synth_a_use_secondary,
  output logic o_synth_b_use_secondary
);

  // ==========================================================================
  // Register file
  // ==========================================================================
  // Select register: buffer modes and reference choices.
  logic [7:0] sel_reg;
  logic [7:0] sel_next;
  // Control register; bits 6 to 3 are stored and read back but steer nothing.
  logic [7:0] ctl_reg;
  logic [7:0] ctl_next;
  // Read data, valid only in the cycle after the read strobe.
  logic [7:0] rd_data_reg;
  logic [7:0] rd_data_next;
  // Decoded strobes.
  logic wr_sel;
  logic wr_ctl;

  assign wr_sel = i_wr_en && (i_addr == rfs_pkg::SEL_OFFSET);
  assign wr_ctl = i_wr_en && (i_addr == rfs_pkg::CTL_OFFSET);

  // Writes store whole bytes; unmapped addresses read as zero.
  always_comb begin
    sel_next = sel_reg;
    ctl_next = ctl_reg;
    rd_data_next = 8'h00;
    if (wr_sel) begin
      sel_next = i_wr_data;
    end
    if (wr_ctl) begin
      ctl_next = i_wr_data;
    end
    if (i_rd_en) begin
      if (i_addr == rfs_pkg::SEL_OFFSET) begin
        rd_data_next = sel_reg;
      end else if (i_addr == rfs_pkg::CTL_OFFSET) begin
        rd_data_next = ctl_reg;
      end
    end
  end

  // Register the file; reset loads the documented defaults.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      sel_reg <= rfs_pkg::SEL_RESET;
      ctl_reg <= rfs_pkg::CTL_RESET;
      rd_data_reg <= 8'h00;
    end else begin
      sel_reg <= sel_next;
      ctl_reg <= ctl_next;
      rd_data_reg <= rd_data_next;
    end
  end

  // ==========================================================================
  // Input synchronisers
  // ==========================================================================
  // The pin level is two bits; each bit is synchronised on its own, so a
  // step from mid to high may show low or high for one cycle. A pin-controlled
  // pick can therefore blip once; the pin should not move while it is in use.
  logic [1:0] pin_meta_reg;
  logic [1:0] pin_sync_reg;
  logic [1:0] lost_meta_reg;
  logic [1:0] lost_sync_reg;

  // Two flip-flops per input; only the second stage is read below.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      pin_meta_reg <= 2'h0;
      pin_sync_reg <= 2'h0;
      lost_meta_reg <= 2'h0;
      lost_sync_reg <= 2'h0;
    end else begin
      pin_meta_reg <= i_ref_pin_level;
      pin_sync_reg <= pin_meta_reg;
      lost_meta_reg <= {i_secondary_lost, i_primary_lost};
      lost_sync_reg <= lost_meta_reg;
    end
  end

  // ==========================================================================
  // Reference choice per synthesizer
  // ==========================================================================
  // Combinational picks for the two synthesizers.
  logic syn_a_sec;
  logic syn_b_sec;

  // Synth A: pin low forces primary.
  rfs_ref_chooser #(
    .IS_SYNTH_B(1'b0)
  ) u_chooser_a (
    .i_choice(sel_reg[rfs_pkg::SYN_A_LSB +: 2]),
    .i_pin_level(pin_sync_reg),
    .i_primary_lost(lost_sync_reg[0]),
    .i_secondary_lost(lost_sync_reg[1]),
    .o_use_secondary(syn_a_sec)
  );

  // Synth B: pin low or mid forces secondary.
  rfs_ref_chooser #(
    .IS_SYNTH_B(1'b1)
  ) u_chooser_b (
    .i_choice(sel_reg[rfs_pkg::SYN_B_LSB +: 2]),
    .i_pin_level(pin_sync_reg),
    .i_primary_lost(lost_sync_reg[0]),
    .i_secondary_lost(lost_sync_reg[1]),
    .o_use_secondary(syn_b_sec)
  );

  // ==========================================================================
  // Output controls
  // ==========================================================================
  // Fields taken apart for readability.
  logic [1:0] sec_mode;
  logic [1:0] pri_mode;
  // Sticky: a synthesizer changed input since the select register was written.
  logic switched_reg;
  logic switched_next;
  logic switch_event;
  // Next values of the registered outputs.
  logic pri_on_next;
  logic sec_on_next;

  assign sec_mode = sel_reg[rfs_pkg::SEC_MODE_LSB +: 2];
  assign pri_mode = sel_reg[rfs_pkg::PRI_MODE_LSB +: 2];
  assign switch_event = (syn_a_sec != o_synth_a_use_secondary) ||
                        (syn_b_sec != o_synth_b_use_secondary);

  // Decode the buffer controls. A crystal that nobody uses any more is shut
  // down after a switch to save power, unless software asks to keep it warm
  // for a fast return. A new select write rearms the crystal.
  always_comb begin
    switched_next = switched_reg;
    if (wr_sel) begin
      switched_next = 1'b0;
    end
    // The switch wins over a clearing write in the same cycle.
    if (switch_event) begin
      switched_next = 1'b1;
    end
    pri_on_next = !pri_mode[1];
    sec_on_next = (sec_mode != rfs_pkg::BUF_OFF);
    if ((sec_mode == rfs_pkg::BUF_CRYSTAL) && switched_reg && !syn_a_sec && !syn_b_sec &&
        !ctl_reg[rfs_pkg::KEEP_ON_BIT]) begin
      sec_on_next = 1'b0;
    end
  end

  // Every output comes from a flip-flop, one cycle behind the registers.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      switched_reg <= 1'b0;
      o_primary_buf_mode <= rfs_pkg::BUF_DIFF;
      o_primary_buf_on <= 1'b1;
      o_primary_buf_gain_max <= 1'b1;
      o_secondary_buf_mode <= rfs_pkg::BUF_CRYSTAL;
      o_secondary_buf_on <= 1'b1;
      o_secondary_buf_gain_max <= 1'b1;
      o_glitchfree_mux_skip <= 1'b0;
      o_synth_a_use_secondary <= 1'b0;
      o_synth_b_use_secondary <= 1'b0;
    end else begin
      switched_reg <= switched_next;
      o_primary_buf_mode <= pri_mode;
      o_primary_buf_on <= pri_on_next;
      o_primary_buf_gain_max <= ctl_reg[rfs_pkg::PRI_GAIN_BIT];
      o_secondary_buf_mode <= sec_mode;
      o_secondary_buf_on <= sec_on_next;
      o_secondary_buf_gain_max <= ctl_reg[rfs_pkg::SEC_GAIN_BIT];
      o_glitchfree_mux_skip <= ctl_reg[rfs_pkg::MUX_SKIP_BIT];
      o_synth_a_use_secondary <= syn_a_sec;
      o_synth_b_use_secondary <= syn_b_sec;
    end
  end

  assign o_rd_data = rd_data_reg;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);

  // Reset loads both registers with their defaults.
  a_reset_values: assert property (
    @(posedge i_core_clk) disable iff (1'b0)
    !i_rst_n |=> (sel_reg == rfs_pkg::SEL_RESET) && (ctl_reg == rfs_pkg::CTL_RESET))
    else $error("register reset values wrong");

  // Secondary mode three turns the buffer off.
  a_sec_buf_off: assert property (
    (sec_mode == rfs_pkg::BUF_OFF) |=> !o_secondary_buf_on)
    else $error("secondary buffer on while disabled");

  // Primary codes two and three both disable; lower codes enable.
  a_pri_buf_on: assert property (
    1'b1 |=> (o_primary_buf_on == ($past(pri_mode) < 2'h2)))
    else $error("primary buffer enable wrong");

  // Forced secondary on synth B.
  a_synb_forced: assert property (
    (sel_reg[3:2] == rfs_pkg::CHOICE_SEC) |=> o_synth_b_use_secondary)
    else $error("synth B not on secondary");

  // Synth B pin low or mid gives secondary.
  a_synb_pin: assert property (
    (sel_reg[3:2] == rfs_pkg::CHOICE_PIN) && !pin_sync_reg[1] |=> o_synth_b_use_secondary)
    else $error("synth B ignores pin");

  // Forced primary on synth A.
  a_syna_forced: assert property (
    (sel_reg[1:0] == rfs_pkg::CHOICE_PRI) |=> !o_synth_a_use_secondary)
    else $error("synth A not on primary");

  // Synth A pin low gives primary, even with the primary lost.
  a_syna_pin: assert property (
    (sel_reg[1:0] == rfs_pkg::CHOICE_PIN) && (pin_sync_reg == rfs_pkg::PIN_LOW)
    |=> !o_synth_a_use_secondary)
    else $error("synth A ignores pin");

  // A control write reaches the multiplexer skip two cycles later.
  a_mux_skip_write: assert property (
    wr_ctl ##1 !wr_ctl |=> (o_glitchfree_mux_skip == $past(i_wr_data[7], 2)))
    else $error("mux skip not following write");

  // Keep-on holds a crystal secondary powered.
  a_crystal_kept: assert property (
    ctl_reg[2] && (sec_mode == rfs_pkg::BUF_CRYSTAL) |=> o_secondary_buf_on)
    else $error("crystal dropped while kept");

  // Gains follow a control write two cycles later.
  a_gain_write: assert property (
    wr_ctl ##1 !wr_ctl |=> (o_secondary_buf_gain_max == $past(i_wr_data[1], 2)) &&
    (o_primary_buf_gain_max == $past(i_wr_data[0], 2)))
    else $error("gain not following write");

  // Automatic mode: lost primary with live secondary moves synth A over.
  a_auto_switch: assert property (
    (sel_reg[1:0] == rfs_pkg::CHOICE_AUTO)
    |=> (o_synth_a_use_secondary == ($past(lost_sync_reg) == 2'h1)))
    else $error("automatic pick wrong");

  // Synth B pin high hands over to the automatic pick.
  a_synb_pin_high: assert property (
    (sel_reg[3:2] == rfs_pkg::CHOICE_PIN) && pin_sync_reg[1]
    |=> (o_synth_b_use_secondary == ($past(lost_sync_reg) == 2'h1)))
    else $error("synth B pin high not automatic");

  // Synth A pin mid or high hands over to the automatic pick.
  a_syna_pin_auto: assert property (
    (sel_reg[1:0] == rfs_pkg::CHOICE_PIN) && (pin_sync_reg != rfs_pkg::PIN_LOW)
    |=> (o_synth_a_use_secondary == ($past(lost_sync_reg) == 2'h1)))
    else $error("synth A pin mid or high not automatic");

  // Forced primary on synth B.
  a_synb_forced_pri: assert property (
    (sel_reg[3:2] == rfs_pkg::CHOICE_PRI) |=> !o_synth_b_use_secondary)
    else $error("synth B not on primary");

  // A change of source always sets the sticky flag, even beside a clearing write.
  a_switch_sticky: assert property (
    switch_event |=> switched_reg)
    else $error("switch not remembered");

  // A crystal that still feeds a synthesizer is never shut down.
  a_crystal_in_use: assert property (
    (sec_mode == rfs_pkg::BUF_CRYSTAL) && (syn_a_sec || syn_b_sec) |=> o_secondary_buf_on)
    else $error("crystal dropped while in use");

  // Scenarios worth seeing.
  c_auto_to_sec: cover property (
    (sel_reg[1:0] == rfs_pkg::CHOICE_AUTO) ##1 $rose(o_synth_a_use_secondary));
  c_crystal_drop: cover property ($fell(o_secondary_buf_on) && (sec_mode == rfs_pkg::BUF_CRYSTAL));
  c_pin_high_b: cover property ((sel_reg[3:2] == rfs_pkg::CHOICE_PIN) && pin_sync_reg[1]);
  c_mux_skip_on: cover property ($rose(o_glitchfree_mux_skip));

endmodule // rfs_reference_input_select

// ==== tb/rfs_ref_source_model.sv ====
`timescale 1ns/1ps
// ============================================================================
// Far-side model: reference monitors and the three-level selection pin
// ============================================================================
// The pin and loss flags are asynchronous to the core, so they move on the
// falling edge, half a cycle away from the edge where the block samples.
module rfs_ref_source_model (
  // Core clock, used only to place changes away from the sampling edge.
  input wire logic i_core_clk,
  // Commands from the bench.
  input wire logic [1:0] i_pin_cmd,
  input wire logic i_plost_cmd,
  input wire logic i_slost_cmd,
  // Levels seen by the block.
  output logic [1:0] o_pin_level,
  output logic o_primary_lost,
  output logic o_secondary_lost
);
  // Start defined so the block never samples an unknown pin.
  initial begin
    o_pin_level = 2'h0;
    o_primary_lost = 1'b0;
    o_secondary_lost = 1'b0;
  end

  // All bits move together, so the block never sees a half-changed code.
  always @(negedge i_core_clk) begin
    o_pin_level <= i_pin_cmd;
    o_primary_lost <= i_plost_cmd;
    o_secondary_lost <= i_slost_cmd;
  end
endmodule // rfs_ref_source_model

// ==== tb/rfs_reference_input_select_tb.sv ====
`timescale 1ns/1ps
// ============================================================================
// Self-checking bench for the reference input selection block
// ============================================================================
module rfs_reference_input_select_tb;
  // Stimulus, all defined at time zero.
  logic clk = 1'b0, rst_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0, chk = 1'b0, rd_d = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00;
  logic [1:0] pin = 2'h0;
  logic plost = 1'b0, slost = 1'b0;
  // Design outputs and the pins coming from the far-side model.
  logic [7:0] rd_data;
  logic [1:0] pmode, smode, pin_lvl;
  logic pon, pgain, son, sgain, skip, a_sec, b_sec, p_lost, s_lost;
  // Output vector in the order of the expected notes.
  logic [10:0] outs;
  // Reference model state: registers, far side and the sticky switch flag.
  logic [7:0] msel = 8'h95, mctl = 8'h03;
  logic [1:0] mpin = 2'h0;
  logic mpl = 1'b0, msl = 1'b0, ma = 1'b0, mb = 1'b0, msw = 1'b0;
  // Expected results, oldest first.
  logic [7:0] rdq[$];
  logic [10:0] outq[$];
  int bad_count = 0;
  int n_compared = 0;

  initial begin
    forever #4 clk = ~clk;
  end

  rfs_ref_source_model u_src (.i_core_clk(clk), .i_pin_cmd(pin), .i_plost_cmd(plost),
    .i_slost_cmd(slost), .o_pin_level(pin_lvl), .o_primary_lost(p_lost),
    .o_secondary_lost(s_lost));

  rfs_reference_input_select u_dut (.i_core_clk(clk), .i_rst_n(rst_n), .i_addr(addr),
    .i_wr_data(wdata), .i_wr_en(wr_en), .i_rd_en(rd_en), .o_rd_data(rd_data),
    .i_ref_pin_level(pin_lvl), .i_primary_lost(p_lost), .i_secondary_lost(s_lost),
    .o_primary_buf_mode(pmode), .o_primary_buf_on(pon), .o_primary_buf_gain_max(pgain),
    .o_secondary_buf_mode(smode), .o_secondary_buf_on(son),
    .o_secondary_buf_gain_max(sgain), .o_glitchfree_mux_skip(skip),
    .o_synth_a_use_secondary(a_sec), .o_synth_b_use_secondary(b_sec));

  assign outs = {pmode, pon, pgain, smode, son, sgain, skip, a_sec, b_sec};

  // ==========================================================================
  // Reference model
  // ==========================================================================
  // Source of one synthesizer: high means the secondary input.
  function automatic logic pick(input logic [1:0] c, input logic isb);
    logic au;
    au = mpl && !msl;
    case (c)
      2'h0: pick = au;
      2'h1: pick = isb ? ((mpin < 2'h2) ? 1'b1 : au) : ((mpin == 2'h0) ? 1'b0 : au);
      2'h2: pick = 1'b0;
      default: pick = 1'b1;
    endcase
  endfunction

  // A select write clears the switch flag; any change of source sets it.
  task automatic upd(input logic clr);
    logic a, b;
    a = pick(msel[1:0], 1'b0);
    b = pick(msel[3:2], 1'b1);
    if (clr) begin
      msw = 1'b0;
    end
    if (a !== ma || b !== mb) begin
      msw = 1'b1;
    end
    ma = a;
    mb = b;
  endtask

  // Expected output vector in the order of the monitor's concatenation.
  function automatic logic [10:0] exp_vec();
    logic on;
    on = (msel[7:6] != 2'h3) && !(msel[7:6] == 2'h2 && msw && !mctl[2] && !ma && !mb);
    exp_vec = {msel[5:4], msel[5:4] < 2'h2, mctl[0], msel[7:6], on, mctl[1], mctl[7], ma, mb};
  endfunction

  // ==========================================================================
  // Drivers
  // ==========================================================================
  // One bus cycle; every signal is assigned once, so cycles may abut.
  task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    wr_en <= w;
    rd_en <= r;
    addr <= a;
    wdata <= d;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    rdq.push_back(e);
    bus(1'b0, 1'b1, a, 8'h00);
  endtask

  task automatic chk_out(input logic [10:0] e);
    outq.push_back(e);
    chk <= 1'b1;
    @(posedge clk);
    chk <= 1'b0;
  endtask

  // Program both registers, then move the far side, then check everything.
  task automatic step(input logic [7:0] s, input logic [7:0] c, input logic [1:0] p,
                      input logic pl, input logic sl);
    bus(1'b1, 1'b0, 8'h32, s);
    bus(1'b1, 1'b0, 8'h33, c);
    bus(1'b0, 1'b0, 8'h00, 8'h00);
    msel = s;
    mctl = c;
    repeat (5) @(posedge clk);
    upd(1'b1);
    pin <= p;
    plost <= pl;
    slost <= sl;
    mpin = p;
    mpl = pl;
    msl = sl;
    repeat (6) @(posedge clk);
    upd(1'b0);
    chk_out(exp_vec());
    rd(8'h32, s);
    rd(8'h33, c);
    bus(1'b0, 1'b0, 8'h00, 8'h00);
  endtask

  // ==========================================================================
  // Monitor and comparisons
  // ==========================================================================
  task automatic cmp_rd(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %0t read data %h expected %h", $time, g, e);
    end
  endtask

  task automatic cmp_out(input logic [10:0] g, input logic [10:0] e);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %0t outputs %h expected %h", $time, g, e);
    end
  endtask

  // Read data stands only in the cycle after the strobe, so look there.
  always @(posedge clk) begin
    rd_d <= rd_en;
    if (rd_d) begin
      cmp_rd(rd_data, rdq.pop_front());
    end
    if (chk) begin
      cmp_out(outs, outq.pop_front());
    end
  end

  task automatic final_report;
    // A note left in a queue means a result never appeared.
    if (rdq.size() != 0 || outq.size() != 0) begin
      bad_count++;
      $display("ERROR %0t results still expected", $time);
    end
    $display("Comparisons %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // The whole run needs about 2000 cycles; this allows ample margin.
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    $display("ERROR %0t watchdog expired", $time);
    final_report();
  end

  // ==========================================================================
  // Test sequence
  // ==========================================================================
  initial begin
    void'($urandom(32'hC4E219DB));
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    upd(1'b0);
    chk_out(exp_vec());
    rd(8'h32, 8'h95);
    rd(8'h33, 8'h03);
    bus(1'b0, 1'b0, 8'h00, 8'h00);
    $display("Test reset_values finished");
    // Unmapped accesses are ignored; a read right after a write sees it.
    bus(1'b1, 1'b0, 8'h34, 8'hFF);
    rd(8'h31, 8'h00);
    bus(1'b1, 1'b0, 8'h33, 8'hF8);
    rd(8'h33, 8'hF8);
    rd(8'h32, 8'h95);
    bus(1'b1, 1'b0, 8'h33, 8'h03);
    bus(1'b0, 1'b0, 8'h00, 8'h00);
    $display("Test register_port finished");
    // Every field code against every pin level and loss combination.
    for (int i = 0; i < 64; i++) begin
      step({4{i[1:0]}}, {i[4], i[3:0], i[2:0]}, i[3:2], i[4], i[5]);
    end
    $display("Test code_table finished");
    // Crystal secondary: a switch back to primary powers it down unless kept.
    for (int k = 0; k < 4; k++) begin
      step(8'h80, {5'h00, k[1], 2'h3}, 2'h2, (k % 2 == 0), 1'b0);
    end
    $display("Test crystal_switch finished");
    for (int j = 0; j < 40; j++) begin
      step(8'($urandom), 8'($urandom), 2'($urandom), 1'($urandom), 1'($urandom));
    end
    $display("Test random_mix finished");
    // Let the monitor take the last read before the verdict.
    @(posedge clk);
    final_report();
  end
endmodule // rfs_reference_input_select_tb
